// *** qdt_cfg.svh ***
// Constants for the quad DAC load and thermal output block.
// Assumes inclusion by its bare name from the package and the design file.
`ifndef QDT_CFG_SVH
`define QDT_CFG_SVH

// Register offsets
`define QDT_ADDR_CODE_FIRST   8'h10
`define QDT_ADDR_CODE_LAST    8'h17
`define QDT_ADDR_CTRL3        8'h1A
`define QDT_ADDR_DAC_CFG      8'h1B
`define QDT_ADDR_LOAD_CFG     8'h1C
`define QDT_ADDR_INT_OFFSET   8'h21
`define QDT_ADDR_EXT_OFFSET   8'h22

// Control configuration 3 fields
`define QDT_C3_RES_10B        1
`define QDT_C3_UPD_SRC        3
`define QDT_C3_THERM_A        5
`define QDT_C3_THERM_B        6

// DAC configuration fields
`define QDT_DC_GAIN_LSB       0
`define QDT_DC_LOAD_A         4
`define QDT_DC_LOAD_B         5
`define QDT_DC_STORED_MASK    8'h0F

// Load configuration fields
`define QDT_LC_LOAD           0
`define QDT_LC_REF_INT        3
`define QDT_LC_PWR_DOWN       4
`define QDT_LC_STORED_MASK    8'h18

// Reset values
`define QDT_RST_CTRL3         8'h00
`define QDT_RST_DAC_CFG       8'h00
`define QDT_RST_LOAD_CFG      8'h00
`define QDT_RST_OFFSET        8'hD8
`define QDT_RST_BYTE          8'h00

// Thermal code limits
`define QDT_FULL_8B           10'h0FF
`define QDT_FULL_10B          10'h3FF

// Thermal working code: top bit of the 12-bit code, saturation flag, top reading
`define QDT_THERM_MSB         11
`define QDT_THERM_SAT         12
`define QDT_TEMP_TOP_DEG      8'h7F

`endif

// *** qdt_pkg.sv ***
// Types shared by the quad DAC load and thermal output block.
// Assumes qdt_cfg.svh sits in the same folder.
`default_nettype none

package qdt_pkg;
    `include "qdt_cfg.svh"

    // One register access from the serial engine
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } qdt_reg_req_t;

    // One completed temperature measurement, signed quarter degrees
    typedef struct packed {
        logic       valid;
        logic [9:0] value;
    } qdt_temp_t;
endpackage

`default_nettype wire

// *** qdt_quad_dac_ctrl.sv ***
// Digital control of a quad voltage-output DAC with thermal output mode.
// Assumes a serial engine issues one-cycle register accesses and the ADC side
// reports each finished temperature reading with a one-cycle valid pulse.
//
// What this block does
// - Written codes wait in a pending register; outputs change only on load or thermal refresh.
// - Reading a code register returns the code now driving the output.
// - Load comes from load pin falling edge, config load bits, or load register.
// - Load configuration register selects reference; external after reset.
// - Per-DAC gain bit: 0 gives gain of one, 1 gives gain of two.
// - Codes are straight binary with full scale set by DAC resolution.
// - Thermal select bits make DAC A follow internal, B external temperature.
// - In thermal mode each finished measurement refreshes the output directly.
// - On 8-bit parts the thermal code moves one step per degree.
// - Wider parts default to 8-bit thermal codes; resolution bit gives quarter degrees.
// - One 8-bit zero-point offset register per sensor, one degree resolution.
// - Offset is twos complement; negative values carry bit seven set.
// - Thermal code is temperature minus offset, in degrees or quarter degrees.
// - Default zero point is -40 degrees; codes saturate, giving an upper deadband.
// - Power-down turns all DAC outputs off into high impedance.
// - After reset the pin loads; update source bit hands loading to registers.
// - After reset all outputs sit at zero until codes are written and loaded.
`timescale 1ns/100ps
`default_nettype none
`include "qdt_cfg.svh"

module qdt_quad_dac_ctrl
    import qdt_pkg::*;
#(
    parameter int DAC_BITS = 12
) (
    input  wire logic                       ref_clk,
    input  wire logic                       srst,
    input  wire qdt_reg_req_t               reg_req,
    output var  logic [7:0]                 reg_rdata,
    output var  logic                       reg_rd_valid,
    input  wire logic                       dac_load_strobe_n,
    input  wire qdt_temp_t                  temp_int,
    input  wire qdt_temp_t                  temp_ext,
    output var  logic [3:0][DAC_BITS-1:0]   dac_code,
    output var  logic [3:0]                 dac_gain_x2,
    output var  logic                       dac_ref_internal,
    output var  logic                       dac_power_down,
    output var  logic [1:0]                 upper_deadband
);

    // Only the three documented resolutions are served; the thermal slices
    // take the top DAC_BITS of a 12-bit working code
    if (DAC_BITS != 8 && DAC_BITS != 10 && DAC_BITS != 12) begin : g_bad_bits
        $error("qdt_quad_dac_ctrl: DAC_BITS must be 8, 10 or 12");
    end

    localparam int NUM_DACS = 4;

    // Register state; pending codes are 16 wide so byte writes need no masking
    logic [7:0]                 ctrl3_reg;
    logic [7:0]                 dac_cfg_reg;
    logic [7:0]                 load_cfg_reg;
    logic [7:0]                 int_offset_reg;
    logic [7:0]                 ext_offset_reg;
    logic [NUM_DACS-1:0][15:0]  pend_reg;
    logic                       load_pin_prev_reg;

    // Decoded write strobes and load sources
    logic       wr_ctrl3;
    logic       wr_dac_cfg;
    logic       wr_load_cfg;
    logic       wr_int_off;
    logic       wr_ext_off;
    logic       wr_code;
    logic [2:0] code_sel;
    logic       upd_by_regs;
    logic       res_10b;
    logic       load_pin;
    logic       load_cfg_bits;
    logic       load_reg_bit;
    logic       load_now;
    logic [12:0] therm_a;
    logic [12:0] therm_b;

    // Thermal code: sign-extended temperature minus offset, clamped at both ends.
    // Offsets are whole degrees and readings quarter degrees, so the offset is
    // scaled by four first; a reading below the zero point gives code zero.
    function automatic logic [12:0] therm_code(
        input logic [9:0] temp_q,
        input logic [7:0] offset_deg,
        input logic       res10
    );
        logic signed [11:0] diff;
        logic [11:0]        code12;
        logic               sat;
        diff   = $signed({{2{temp_q[9]}}, temp_q})
               - $signed({{2{offset_deg[7]}}, offset_deg, 2'b00});
        code12 = 12'h000;
        // At +127 degrees the reading can rise no further, so the output is stuck
        sat    = (temp_q[9:2] == `QDT_TEMP_TOP_DEG);
        if (diff < 0) begin
            code12 = 12'h000;
        end else if (res10) begin
            if (diff[11:0] > {2'b00, `QDT_FULL_10B}) begin
                sat    = 1'b1;
                code12 = {`QDT_FULL_10B, 2'b00};
            end else begin
                code12 = {diff[9:0], 2'b00};
            end
        end else begin
            if (diff[11:2] > `QDT_FULL_8B) begin
                sat    = 1'b1;
                code12 = {8'(`QDT_FULL_8B), 4'h0};
            end else begin
                code12 = {diff[9:2], 4'h0};
            end
        end
        return {sat, code12};
    endfunction

    // Byte view of a code: low byte at even address, high bits at odd address
    // Bits above the DAC width read back as zero
    function automatic logic [7:0] code_byte(
        input logic [DAC_BITS-1:0] code,
        input logic                hi
    );
        logic [15:0] wide;
        wide = 16'h0000;
        wide[DAC_BITS-1:0] = code;
        return hi ? wide[15:8] : wide[7:0];
    endfunction

    // True for the eight code byte addresses
    function automatic logic is_code_addr(input logic [7:0] addr);
        return (addr >= `QDT_ADDR_CODE_FIRST) && (addr <= `QDT_ADDR_CODE_LAST);
    endfunction

    // Address decode of writes; unmapped addresses raise no strobe
    always_comb begin
        wr_ctrl3   = 1'b0;
        wr_dac_cfg = 1'b0;
        wr_load_cfg = 1'b0;
        wr_int_off = 1'b0;
        wr_ext_off = 1'b0;
        wr_code    = 1'b0;
        if (reg_req.wr) begin
            if (is_code_addr(reg_req.addr)) begin
                wr_code = 1'b1;
            end else if (reg_req.addr == `QDT_ADDR_CTRL3) begin
                wr_ctrl3 = 1'b1;
            end else if (reg_req.addr == `QDT_ADDR_DAC_CFG) begin
                wr_dac_cfg = 1'b1;
            end else if (reg_req.addr == `QDT_ADDR_LOAD_CFG) begin
                wr_load_cfg = 1'b1;
            end else if (reg_req.addr == `QDT_ADDR_INT_OFFSET) begin
                wr_int_off = 1'b1;
            end else if (reg_req.addr == `QDT_ADDR_EXT_OFFSET) begin
                wr_ext_off = 1'b1;
            end
        end
    end

    // Which of the eight code bytes is addressed
    assign code_sel = 3'(reg_req.addr - `QDT_ADDR_CODE_FIRST);

    // Load source selection and command merge
    // Only one source is live: in pin mode the register load bits are ignored,
    // in register mode the pin is ignored
    assign upd_by_regs   = ctrl3_reg[`QDT_C3_UPD_SRC];
    assign load_pin      = load_pin_prev_reg & ~dac_load_strobe_n;
    assign load_cfg_bits = wr_dac_cfg
                         & (reg_req.wdata[`QDT_DC_LOAD_A] | reg_req.wdata[`QDT_DC_LOAD_B]);
    assign load_reg_bit  = wr_load_cfg & reg_req.wdata[`QDT_LC_LOAD];
    assign load_now      = upd_by_regs ? (load_cfg_bits | load_reg_bit)
                                       : load_pin;

    // Quarter-degree thermal mode only exists on wider parts
    assign res_10b = (DAC_BITS > 8) && ctrl3_reg[`QDT_C3_RES_10B];

    assign therm_a = therm_code(temp_int.value, int_offset_reg, res_10b);
    assign therm_b = therm_code(temp_ext.value, ext_offset_reg, res_10b);

    // Load pin history; starts as if low, so a pin held low through reset
    // gives no falling edge and the host must raise it first
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            load_pin_prev_reg <= 1'b0;
        end else begin
            load_pin_prev_reg <= dac_load_strobe_n;
        end
    end

    // Control configuration 3, whole byte kept
    // so a read returns exactly what was written
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl3_reg <= `QDT_RST_CTRL3;
        end else if (wr_ctrl3) begin
            ctrl3_reg <= reg_req.wdata;
        end
    end

    // DAC configuration; load bits act on write and are not stored
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dac_cfg_reg <= `QDT_RST_DAC_CFG;
        end else if (wr_dac_cfg) begin
            dac_cfg_reg <= reg_req.wdata & `QDT_DC_STORED_MASK;
        end
    end

    // Load configuration: reference select and power-down kept, load bit pulses
    // Reference select resets to external
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            load_cfg_reg <= `QDT_RST_LOAD_CFG;
        end else if (wr_load_cfg) begin
            load_cfg_reg <= reg_req.wdata & `QDT_LC_STORED_MASK;
        end
    end

    // Zero-point offset registers, one per sensor
    // Both start at the default zero point of -40 degrees
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            int_offset_reg <= `QDT_RST_OFFSET;
            ext_offset_reg <= `QDT_RST_OFFSET;
        end else begin
            if (wr_int_off) begin
                int_offset_reg <= reg_req.wdata;
            end
            if (wr_ext_off) begin
                ext_offset_reg <= reg_req.wdata;
            end
        end
    end

    // Pending codes written byte by byte
    // Bytes land here only; nothing reaches the outputs before a load
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pend_reg <= '0;
        end else if (wr_code) begin
            if (code_sel[0]) begin
                pend_reg[code_sel[2:1]][15:8] <= reg_req.wdata;
            end else begin
                pend_reg[code_sel[2:1]][7:0]  <= reg_req.wdata;
            end
        end
    end

    // Active codes: load moves all pending codes at once, thermal mode overrides
    // A refresh wins over a same-cycle load on A or B, so the output always
    // tracks the newest reading while its select bit is set
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dac_code <= '0;
        end else begin
            for (int i = 0; i < NUM_DACS; i++) begin
                if (load_now) begin
                    dac_code[i] <= pend_reg[i][DAC_BITS-1:0];
                end
            end
            if (ctrl3_reg[`QDT_C3_THERM_A]) begin
                if (temp_int.valid) begin
                    dac_code[0] <= therm_a[`QDT_THERM_MSB -: DAC_BITS];
                end else begin
                    dac_code[0] <= dac_code[0];
                end
            end
            if (ctrl3_reg[`QDT_C3_THERM_B]) begin
                if (temp_ext.valid) begin
                    dac_code[1] <= therm_b[`QDT_THERM_MSB -: DAC_BITS];
                end else begin
                    dac_code[1] <= dac_code[1];
                end
            end
        end
    end

    // Upper deadband flags follow the last thermal refresh of each channel
    // A flag clears when thermal tracking of its channel is switched off
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            upper_deadband <= 2'b00;
        end else begin
            if (!ctrl3_reg[`QDT_C3_THERM_A]) begin
                upper_deadband[0] <= 1'b0;
            end else if (temp_int.valid) begin
                upper_deadband[0] <= therm_a[`QDT_THERM_SAT];
            end
            if (!ctrl3_reg[`QDT_C3_THERM_B]) begin
                upper_deadband[1] <= 1'b0;
            end else if (temp_ext.valid) begin
                upper_deadband[1] <= therm_b[`QDT_THERM_SAT];
            end
        end
    end

    // Analog control levels, registered from configuration
    // The extra stage keeps these outputs straight from flip-flops
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dac_gain_x2      <= 4'h0;
            dac_ref_internal <= 1'b0;
            dac_power_down   <= 1'b0;
        end else begin
            dac_gain_x2      <= dac_cfg_reg[`QDT_DC_GAIN_LSB +: NUM_DACS];
            dac_ref_internal <= load_cfg_reg[`QDT_LC_REF_INT];
            dac_power_down   <= load_cfg_reg[`QDT_LC_PWR_DOWN];
        end
    end

    // Read path, answered one cycle after the request
    // Code reads return the active code, never the pending one
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata    <= `QDT_RST_BYTE;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_req.rd;
            if (reg_req.rd) begin
                if (is_code_addr(reg_req.addr)) begin
                    reg_rdata <= code_byte(dac_code[code_sel[2:1]], code_sel[0]);
                end else if (reg_req.addr == `QDT_ADDR_CTRL3) begin
                    reg_rdata <= ctrl3_reg;
                end else if (reg_req.addr == `QDT_ADDR_DAC_CFG) begin
                    reg_rdata <= dac_cfg_reg;
                end else if (reg_req.addr == `QDT_ADDR_LOAD_CFG) begin
                    reg_rdata <= load_cfg_reg;
                end else if (reg_req.addr == `QDT_ADDR_INT_OFFSET) begin
                    reg_rdata <= int_offset_reg;
                end else if (reg_req.addr == `QDT_ADDR_EXT_OFFSET) begin
                    reg_rdata <= ext_offset_reg;
                end else begin
                    reg_rdata <= `QDT_RST_BYTE;                           // Unmapped reads zero
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** qdt_quad_dac_props.sv ***
// Checker for the quad DAC control block: port-level timing relations.
// Assumes it is bound into every qdt_quad_dac_ctrl instance.
`timescale 1ns/100ps
`default_nettype none
`include "qdt_cfg.svh"
module qdt_quad_dac_props
    import qdt_pkg::*;
#(
    parameter int DAC_BITS = 12
) (
    input wire logic                     ref_clk,
    input wire logic                     srst,
    input wire qdt_reg_req_t             reg_req,
    input wire logic [7:0]               reg_rdata,
    input wire logic                     reg_rd_valid,
    input wire logic                     dac_load_strobe_n,
    input wire qdt_temp_t                temp_int,
    input wire qdt_temp_t                temp_ext,
    input wire logic [3:0][DAC_BITS-1:0] dac_code,
    input wire logic [3:0]               dac_gain_x2,
    input wire logic                     dac_ref_internal,
    input wire logic                     dac_power_down,
    input wire logic [1:0]               upper_deadband
);
    default clocking dclk @(posedge ref_clk); endclocking
    default disable iff (srst);

    // Events that may legally move a code
    wire logic load_cause = reg_req.wr | ~dac_load_strobe_n;
    wire logic temp_cause = temp_int.valid | temp_ext.valid;
    wire logic lc_wr      = reg_req.wr & (reg_req.addr == `QDT_ADDR_LOAD_CFG);

    // Read answers and their timing
    rd_answer_a: assert property (reg_req.rd |=> reg_rd_valid) else $error("read not answered");
    rd_quiet_a: assert property (!reg_req.rd |=> !reg_rd_valid) else $error("stray read answer");
    rdata_hold_a: assert property ($changed(reg_rdata) && !$past(srst) |-> $past(reg_req.rd))
        else $error("read data moved without read");
    // Codes move only on a load or a temperature result
    code_cd_hold_a: assert property (($changed(dac_code[2]) || $changed(dac_code[3])) && !$past(srst)
        |-> $past(load_cause)) else $error("code moved without load");
    code_ab_hold_a: assert property (($changed(dac_code[0]) || $changed(dac_code[1])) && !$past(srst)
        |-> $past(load_cause | temp_cause)) else $error("code moved without cause");
    // Configuration outputs follow the written bits two edges after the write
    gain_src_a: assert property ($changed(dac_gain_x2) && !$past(srst)
        |-> $past(reg_req.wr && reg_req.addr == `QDT_ADDR_DAC_CFG, 2)
        && $past(reg_req.wdata[3:0], 2) == dac_gain_x2) else $error("gain moved wrongly");
    ref_src_a: assert property ($changed(dac_ref_internal) && !$past(srst)
        |-> $past(lc_wr, 2) && $past(reg_req.wdata[3], 2) == dac_ref_internal)
        else $error("reference moved wrongly");
    pd_src_a: assert property ($changed(dac_power_down) && !$past(srst)
        |-> $past(lc_wr, 2) && $past(reg_req.wdata[4], 2) == dac_power_down)
        else $error("power-down moved wrongly");
    // The flag moves on a reading, or is cleared once its select bit is written off
    ub_src_a: assert property ($changed(upper_deadband) && !$past(srst)
        |-> $past(temp_cause) || $past(reg_req.wr, 2)) else $error("deadband flag moved without reading");
endmodule

bind qdt_quad_dac_ctrl qdt_quad_dac_props #(.DAC_BITS(DAC_BITS)) props_u (
    .ref_clk(ref_clk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .dac_load_strobe_n(dac_load_strobe_n), .temp_int(temp_int), .temp_ext(temp_ext), .dac_code(dac_code),
    .dac_gain_x2(dac_gain_x2), .dac_ref_internal(dac_ref_internal), .dac_power_down(dac_power_down),
    .upper_deadband(upper_deadband));
`default_nettype wire

// *** qdt_host_model.sv ***
// Host model: register accesses and the load pin, driven after rising edges.
// Assumes the one-cycle strobe register bus of the control block.
`timescale 1ns/100ps
`default_nettype none
module qdt_host_model
    import qdt_pkg::*;
(
    input  wire logic         ref_clk,
    output var  qdt_reg_req_t reg_req,
    output var  logic         dac_load_strobe_n,
    input  wire logic [7:0]   reg_rdata,
    input  wire logic         reg_rd_valid
);
    // Idle bus and released load pin
    initial begin
        reg_req = '0;
        dac_load_strobe_n = 1'b1;
    end
    // One write; released address and data show inverted values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_req <= {1'b1, 1'b0, a, d};
        @(posedge ref_clk);
        reg_req <= {1'b0, 1'b0, ~a, ~d};
    endtask
    // One read; gives unknown when no answer marker comes
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_req <= {1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk);
        reg_req <= {1'b0, 1'b0, ~a, 8'hFF};
        #1;
        d = reg_rd_valid ? reg_rdata : 8'hxx;
    endtask
    // Load pin level, held at least one full cycle
    task automatic pin(input logic v);
        @(posedge ref_clk);
        dac_load_strobe_n <= v;
        @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the quad DAC load and thermal output block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`include "qdt_cfg.svh"
module tb_top
    import qdt_pkg::*;
;
    logic             ref_clk;
    logic             srst;
    qdt_reg_req_t     reg_req;
    logic [7:0]       reg_rdata;
    logic             reg_rd_valid;
    logic             dac_load_strobe_n;
    qdt_temp_t        temp_int;
    qdt_temp_t        temp_ext;
    logic [3:0][11:0] dac_code;
    logic [3:0]       dac_gain_x2;
    logic             dac_ref_internal;
    logic             dac_power_down;
    logic [1:0]       upper_deadband;
    int               bad_count;
    int               comparisons;
    int               cycles;

    qdt_quad_dac_ctrl #(.DAC_BITS(12)) dut_u (
        .ref_clk(ref_clk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .dac_load_strobe_n(dac_load_strobe_n), .temp_int(temp_int), .temp_ext(temp_ext), .dac_code(dac_code),
        .dac_gain_x2(dac_gain_x2), .dac_ref_internal(dac_ref_internal), .dac_power_down(dac_power_down),
        .upper_deadband(upper_deadband));
    qdt_host_model host_u (
        .ref_clk(ref_clk), .reg_req(reg_req), .dac_load_strobe_n(dac_load_strobe_n),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));

    // Clock and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            close_out();
        end
    end

    task automatic close_out();
        if (bad_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host_u.rd(a, d);
        chk(n, {8'h00, e}, {8'h00, d});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // One temperature result pulse; released value shows inverted
    task automatic temp(input logic ext, input logic [9:0] v);
        @(posedge ref_clk);
        if (ext) begin
            temp_ext <= {1'b1, v};
        end else begin
            temp_int <= {1'b1, v};
        end
        @(posedge ref_clk);
        temp_int <= {1'b0, ~v};
        temp_ext <= {1'b0, ~v};
        #1;
    endtask

    task automatic t_reset();
        tick(1);
        for (int i = 0; i < 4; i++) begin
            chk("dac_code", 16'h0000, dac_code[i]);
        end
        chk("ref_internal", 16'h0000, dac_ref_internal);
        chk("power_down", 16'h0000, dac_power_down);
        rchk("int_offset", `QDT_ADDR_INT_OFFSET, 8'hD8);
        rchk("ext_offset", `QDT_ADDR_EXT_OFFSET, 8'hD8);
        rchk("unmapped", 8'h30, 8'h00);
    endtask
    task automatic t_pin_load();
        host_u.wr(8'h10, 8'h34);
        host_u.wr(8'h11, 8'h0A);
        host_u.wr(8'h16, 8'hFF);
        host_u.wr(8'h17, 8'h0F);
        rchk("code_a_lo", 8'h10, 8'h00);
        chk("held_a", 16'h0000, dac_code[0]);
        host_u.pin(1'b0);
        tick(1);
        chk("pin_load_a", 16'h0A34, dac_code[0]);
        chk("pin_load_d", 16'h0FFF, dac_code[3]);
        rchk("code_a_hi", 8'h11, 8'h0A);
        host_u.wr(8'h10, 8'h11);
        tick(3);
        chk("low_no_reload", 16'h0A34, dac_code[0]);
        host_u.pin(1'b1);
        host_u.pin(1'b0);
        tick(1);
        chk("second_load", 16'h0A11, dac_code[0]);
        host_u.pin(1'b1);
    endtask
    task automatic t_reg_load();
        host_u.wr(`QDT_ADDR_CTRL3, 8'h08);
        host_u.wr(8'h12, 8'h55);
        host_u.pin(1'b0);
        host_u.pin(1'b1);
        tick(1);
        chk("pin_ignored", 16'h0000, dac_code[1]);
        host_u.wr(`QDT_ADDR_DAC_CFG, 8'h10);
        tick(1);
        chk("cfg_load_a", 16'h0055, dac_code[1]);
        host_u.wr(8'h12, 8'h66);
        host_u.wr(`QDT_ADDR_DAC_CFG, 8'h20);
        tick(1);
        chk("cfg_load_b", 16'h0066, dac_code[1]);
        host_u.wr(8'h12, 8'h77);
        host_u.wr(`QDT_ADDR_LOAD_CFG, 8'h01);
        tick(1);
        chk("lc_load", 16'h0077, dac_code[1]);
        host_u.wr(`QDT_ADDR_DAC_CFG, 8'h0F);
        tick(1);
        chk("gain", 16'h000F, dac_gain_x2);
        rchk("dac_cfg", `QDT_ADDR_DAC_CFG, 8'h0F);
        host_u.wr(`QDT_ADDR_LOAD_CFG, 8'h18);
        tick(1);
        chk("ref_int_set", 16'h0001, dac_ref_internal);
        chk("pd_set", 16'h0001, dac_power_down);
        rchk("load_cfg", `QDT_ADDR_LOAD_CFG, 8'h18);
        temp(1'b0, 10'h000);
        chk("thermal_off", 16'h0A11, dac_code[0]);
    endtask
    task automatic t_thermal();
        host_u.wr(`QDT_ADDR_CTRL3, 8'h68);
        temp(1'b0, 10'h000);
        chk("therm_a_0c", 16'h0280, dac_code[0]);
        host_u.wr(`QDT_ADDR_EXT_OFFSET, 8'h0A);
        temp(1'b1, 10'h1FC);
        chk("therm_b_127c", 16'h0750, dac_code[1]);
        chk("deadband_top", 16'h0002, upper_deadband);
        temp(1'b1, 10'h000);
        chk("therm_b_below", 16'h0000, dac_code[1]);
        chk("deadband_clear", 16'h0000, upper_deadband);
        host_u.wr(`QDT_ADDR_CTRL3, 8'h6A);
        temp(1'b0, 10'h03D);
        chk("therm_a_10b", 16'h0374, dac_code[0]);
        host_u.wr(`QDT_ADDR_INT_OFFSET, 8'h80);
        temp(1'b0, 10'h360);
        chk("therm_a_neg", 16'h0580, dac_code[0]);
        chk("d_untouched", 16'h0FFF, dac_code[3]);
    endtask
    // Reset in mid-run with the load pin held low through it
    task automatic t_mid_reset();
        host_u.pin(1'b0);
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        host_u.wr(8'h10, 8'h12);
        tick(1);
        chk("rst_code_a", 16'h0000, dac_code[0]);
        chk("rst_gain", 16'h0000, dac_gain_x2);
        chk("rst_pd", 16'h0000, dac_power_down);
        chk("rst_deadband", 16'h0000, upper_deadband);
        rchk("rst_ctrl3", `QDT_ADDR_CTRL3, 8'h00);
        host_u.pin(1'b1);
        host_u.pin(1'b0);
        tick(1);
        chk("rst_pin_load", 16'h0012, dac_code[0]);
    endtask

    // Main sequence
    initial begin
        srst = 1'b1;
        temp_int = '0;
        temp_ext = '0;
        bad_count = 0;
        comparisons = 0;
        cycles = 0;
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset();
        t_pin_load();
        t_reg_load();
        t_thermal();
        t_mid_reset();
        close_out();
    end
endmodule
`default_nettype wire
